//--- dmr_ctrl_sva.sv
`timescale 1ns/100ps
module dmr_ctrl_sva #(
    parameter int STEP_SAMPLES = 8
) (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       CTRL_SHIFT_CLK,
    input wire logic       CTRL_SELECT_N,
    input wire logic       CTRL_SERIAL_IN,
    input wire logic       SAMPLE_TICK,
    input wire logic       LEFT_ZERO_CROSS,
    input wire logic       RIGHT_ZERO_CROSS,
    input wire logic [5:0] LEFT_GAIN_LEVEL,
    input wire logic [5:0] RIGHT_GAIN_LEVEL,
    input wire logic       OVERSAMPLE_HIGH,
    input wire logic       RIGHT_POLARITY_FLIP,
    input wire logic       LINE_IN_BLEND_EN,
    input wire logic       TREBLE_CUT_FILTER_EN,
    input wire logic [2:0] AUDIO_WORD_LAYOUT,
    input wire logic       ZERO_CROSSING_GAIN_STEP,
    input wire logic       LOW_POWER_REQ,
    input wire logic       DIGITAL_RESET
);
    // ****************************************
    // ticks seen since the last left level move
    // ****************************************
    logic [5:0] prev_left_reg;
    logic [7:0] tick_cnt_reg;
    logic [7:0] tick_cnt_next;
    logic [7:0] cfg_bits;

    assign cfg_bits = {OVERSAMPLE_HIGH, RIGHT_POLARITY_FLIP, LINE_IN_BLEND_EN, TREBLE_CUT_FILTER_EN,
                       AUDIO_WORD_LAYOUT, ZERO_CROSSING_GAIN_STEP};

    // saturates so that a long idle never wraps into a false short gap
    always_comb begin
        tick_cnt_next = tick_cnt_reg;
        if (RST || DIGITAL_RESET) begin
            tick_cnt_next = 8'hff;
        end else if (LEFT_GAIN_LEVEL != prev_left_reg) begin
            tick_cnt_next = 8'h00;
        end else if (SAMPLE_TICK && tick_cnt_reg != 8'hff) begin
            tick_cnt_next = tick_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        prev_left_reg <= LEFT_GAIN_LEVEL;
        tick_cnt_reg  <= tick_cnt_next;
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_rst_values: assert property (disable iff (1'b0) RST |=> LEFT_GAIN_LEVEL == 6'h3f &&
        RIGHT_GAIN_LEVEL == 6'h3f && cfg_bits == 8'h00 && !LOW_POWER_REQ && DIGITAL_RESET)
        else $error("reset values wrong");
    a_lp_digrst: assert property (LOW_POWER_REQ |=> DIGITAL_RESET)
        else $error("low power did not reset logic");
    a_lp_levels: assert property (DIGITAL_RESET [*2] |-> LEFT_GAIN_LEVEL == 6'h3f &&
        RIGHT_GAIN_LEVEL == 6'h3f) else $error("levels not held in low power");
    a_step_one: assert property ($changed(LEFT_GAIN_LEVEL) && !DIGITAL_RESET && !$past(DIGITAL_RESET) |->
        (LEFT_GAIN_LEVEL == 6'($past(LEFT_GAIN_LEVEL) + 6'h01)) ||
        (LEFT_GAIN_LEVEL == 6'($past(LEFT_GAIN_LEVEL) - 6'h01))) else $error("left step not one");
    a_step_right: assert property ($changed(RIGHT_GAIN_LEVEL) && !DIGITAL_RESET && !$past(DIGITAL_RESET) |->
        (RIGHT_GAIN_LEVEL == 6'($past(RIGHT_GAIN_LEVEL) + 6'h01)) ||
        (RIGHT_GAIN_LEVEL == 6'($past(RIGHT_GAIN_LEVEL) - 6'h01))) else $error("right step not one");
    a_step_tick: assert property ($changed(LEFT_GAIN_LEVEL) && !ZERO_CROSSING_GAIN_STEP && !DIGITAL_RESET &&
        !$past(DIGITAL_RESET) |-> $past(SAMPLE_TICK, 2)) else $error("step not after a sample tick");
    a_step_space: assert property ($changed(LEFT_GAIN_LEVEL) && !ZERO_CROSSING_GAIN_STEP &&
        !DIGITAL_RESET && !$past(DIGITAL_RESET) |-> tick_cnt_reg >= 8'(STEP_SAMPLES))
        else $error("steps closer than the step period");
    a_zc_alternate: assert property (ZERO_CROSSING_GAIN_STEP && $changed(LEFT_GAIN_LEVEL) &&
        !DIGITAL_RESET && !$past(DIGITAL_RESET) |-> $stable(RIGHT_GAIN_LEVEL))
        else $error("both channels moved together");
    a_cfg_frame: assert property ($changed(cfg_bits) || $changed(LOW_POWER_REQ) |->
        $past(CTRL_SELECT_N, 2) && $past(CTRL_SELECT_N, 3)) else $error("register changed inside frame");
endmodule

//--- dmr_ctrl_top.sv
`timescale 1ns/100ps
module dmr_ctrl_top #(
    parameter int STEP_SAMPLES = dmr_pkg::STEP_SAMPLES,
    parameter int ZC_TIMEOUT   = dmr_pkg::ZC_TIMEOUT_SAMPLES
) (
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic       CTRL_SHIFT_CLK,
    input  wire logic       CTRL_SELECT_N,
    input  wire logic       CTRL_SERIAL_IN,
    input  wire logic       SAMPLE_TICK,
    input  wire logic       LEFT_ZERO_CROSS,
    input  wire logic       RIGHT_ZERO_CROSS,
    output logic      [5:0] LEFT_GAIN_LEVEL,
    output logic      [5:0] RIGHT_GAIN_LEVEL,
    output logic            OVERSAMPLE_HIGH,
    output logic            RIGHT_POLARITY_FLIP,
    output logic            LINE_IN_BLEND_EN,
    output logic            TREBLE_CUT_FILTER_EN,
    output logic      [2:0] AUDIO_WORD_LAYOUT,
    output logic            ZERO_CROSSING_GAIN_STEP,
    output logic            LOW_POWER_REQ,
    output logic            DIGITAL_RESET
);
    localparam int FB    = dmr_pkg::FRAME_BITS;
    localparam int CNT_W = $clog2(FB + 1);
    localparam int SC_W  = $clog2(STEP_SAMPLES);

    initial begin
        if (STEP_SAMPLES < 2 || (STEP_SAMPLES & (STEP_SAMPLES - 1)) != 0 || ZC_TIMEOUT < 1) begin
            $error("dmr_ctrl_top: STEP_SAMPLES must be a power of two, ZC_TIMEOUT positive");
        end
    end

    // ************************************************
    // frame decode
    // ************************************************
    // returns 0 for a frame that must be dropped, else the register index
    function automatic logic [2:0] frame_slot(input logic [FB-1:0] w);
        logic [6:0] idx;
        idx = w[dmr_pkg::INDEX_LSB +: dmr_pkg::INDEX_W];
        frame_slot = 3'd0;
        if (!w[dmr_pkg::FRAME_ZERO_BIT]) begin
            case (idx)
                dmr_pkg::IDX_LEFT:   frame_slot = 3'd1;
                dmr_pkg::IDX_RIGHT:  frame_slot = 3'd2;
                dmr_pkg::IDX_FORMAT: frame_slot = 3'd3;
                dmr_pkg::IDX_ZCPWR:  frame_slot = 3'd4;
                default:             frame_slot = 3'd0;
            endcase
        end
    endfunction

    // ************************************************
    // link domain: shift clock
    // ************************************************
    // the shift clock only runs inside frames, so the bit count is
    // cleared by the select line itself while it stands high
    typedef struct packed {
        logic [FB-1:0] shift;
        logic [FB-1:0] hold_word;
        logic          hold_bad;
        logic          hold_tog;
    } dmr_link_state_t;

    localparam dmr_link_state_t LINK_RST = '{
        shift:     '0,
        hold_word: '0,
        hold_bad:  1'b0,
        hold_tog:  1'b0
    };

    dmr_link_state_t l_reg;
    dmr_link_state_t l_next;
    logic [CNT_W-1:0] bit_cnt_reg;
    logic             link_clr;

    assign link_clr = CTRL_SELECT_N | RST;

    always_comb begin
        l_next       = l_reg;
        l_next.shift = {l_reg.shift[FB-2:0], CTRL_SERIAL_IN};
        if (bit_cnt_reg == CNT_W'(FB - 1)) begin
            // sixteenth bit: hand the word over with a toggle event
            l_next.hold_word = {l_reg.shift[FB-2:0], CTRL_SERIAL_IN};
            l_next.hold_bad  = 1'b0;
            l_next.hold_tog  = ~l_reg.hold_tog;
        end else if (bit_cnt_reg == CNT_W'(FB)) begin
            l_next.hold_bad = 1'b1; // overlong frame is discarded
        end
    end

    always_ff @(posedge CTRL_SHIFT_CLK or posedge RST) begin
        if (RST) begin
            l_reg <= LINK_RST;
        end else begin
            l_reg <= l_next;
        end
    end

    // data is captured on the rising edge while select is low
    always_ff @(posedge CTRL_SHIFT_CLK or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_reg <= '0;
        end else if (bit_cnt_reg != CNT_W'(FB)) begin
            bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
        end
    end

    // ************************************************
    // system domain state
    // ************************************************
    typedef struct packed {
        logic [2:0]      sel_sync;
        logic            sel_level;
        logic [2:0]      tog_sync;
        logic            tog_level;
        logic            tog_seen;
        logic [7:0]      left_ctrl;
        logic [7:0]      right_ctrl;
        logic [7:0]      format_ctrl;
        logic [7:0]      zcpwr_ctrl;
        logic [SC_W-1:0] smp_cnt;
        logic            turn;
        logic            eng_rst;
    } dmr_top_state_t;

    localparam dmr_top_state_t TOP_RST = '{
        sel_sync:    3'b111,
        sel_level:   1'b1,
        tog_sync:    3'b000,
        tog_level:   1'b0,
        tog_seen:    1'b0,
        left_ctrl:   dmr_pkg::LEFT_RST,
        right_ctrl:  dmr_pkg::RIGHT_RST,
        format_ctrl: dmr_pkg::FORMAT_RST,
        zcpwr_ctrl:  dmr_pkg::ZCPWR_RST,
        smp_cnt:     '0,
        turn:        1'b0,
        eng_rst:     1'b1
    };

    dmr_top_state_t s_reg;
    dmr_top_state_t s_next;

    logic            zc_mode;
    logic            low_power;
    logic            step_tick;
    logic            sel_rise;
    logic [1:0]      want;
    logic [1:0]      grant;
    logic [1:0]      zero_cross;
    logic [5:0]      target   [2];
    logic [5:0]      level    [2];
    logic [FB-1:0]   rx_word;
    logic [2:0]      rx_slot;

    assign zc_mode   = s_reg.zcpwr_ctrl[dmr_pkg::ZC_BIT];
    assign low_power = s_reg.zcpwr_ctrl[dmr_pkg::LOW_POWER_BIT];
    assign step_tick = SAMPLE_TICK && (s_reg.smp_cnt == {SC_W{1'b1}});
    assign sel_rise  = s_reg.sel_level == 1'b0 && s_reg.sel_sync[1] && s_reg.sel_sync[2];
    // the held word stays still from its toggle until the next frame's end
    assign rx_word   = l_reg.hold_word;
    assign rx_slot   = frame_slot(rx_word);

    // silence forces the target to full mute; clearing it restores the code
    assign target[0] = s_reg.left_ctrl[dmr_pkg::SILENCE_L_BIT] ? dmr_pkg::GAIN_MUTE
                       : s_reg.left_ctrl[dmr_pkg::GAIN_LSB +: dmr_pkg::GAIN_W];
    assign target[1] = s_reg.left_ctrl[dmr_pkg::SILENCE_R_BIT] ? dmr_pkg::GAIN_MUTE
                       : s_reg.right_ctrl[dmr_pkg::GAIN_LSB +: dmr_pkg::GAIN_W];
    assign zero_cross = {RIGHT_ZERO_CROSS, LEFT_ZERO_CROSS};

    // ************************************************
    // channel arbitration
    // ************************************************
    // outside zero-cross mode both channels step together; in it the
    // changes alternate, so a channel waits at most one grant
    always_comb begin
        grant = want;
        if (zc_mode && want == 2'b11) begin
            grant = s_reg.turn ? 2'b10 : 2'b01;
        end
    end

    always_comb begin
        s_next          = s_reg;
        s_next.sel_sync = {s_reg.sel_sync[1:0], CTRL_SELECT_N};
        s_next.tog_sync = {s_reg.tog_sync[1:0], l_reg.hold_tog};
        if (s_reg.sel_sync[1] == s_reg.sel_sync[2]) begin
            s_next.sel_level = s_reg.sel_sync[2];
        end
        if (s_reg.tog_sync[1] == s_reg.tog_sync[2]) begin
            s_next.tog_level = s_reg.tog_sync[2];
        end

        // a frame counts only once select has risen after sixteen bits
        if (sel_rise) begin
            s_next.tog_seen = s_reg.tog_level;
            if (s_reg.tog_level != s_reg.tog_seen && !l_reg.hold_bad) begin
                case (rx_slot)
                    3'd1:    s_next.left_ctrl   = rx_word[dmr_pkg::DATA_W-1:0];
                    3'd2:    s_next.right_ctrl  = rx_word[dmr_pkg::DATA_W-1:0];
                    3'd3:    s_next.format_ctrl = rx_word[dmr_pkg::DATA_W-1:0];
                    3'd4:    s_next.zcpwr_ctrl  = rx_word[dmr_pkg::DATA_W-1:0];
                    default: s_next.left_ctrl   = s_reg.left_ctrl;
                endcase
            end
        end

        // low power clears the engine but never the registers
        s_next.eng_rst = low_power;
        if (s_reg.eng_rst) begin
            s_next.smp_cnt = '0;
            s_next.turn    = 1'b0;
        end else begin
            if (SAMPLE_TICK) begin
                s_next.smp_cnt = s_reg.smp_cnt + SC_W'(1);
            end
            if (grant == 2'b01) begin
                s_next.turn = 1'b1;
            end else if (grant == 2'b10) begin
                s_next.turn = 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s_reg <= TOP_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************
    // per-channel attenuators
    // ************************************************
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            dmr_gain_ramp #(
                .GAIN_W  (dmr_pkg::GAIN_W),
                .TIMEOUT (ZC_TIMEOUT)
            ) u_ramp (
                .clk         (MCLK),
                .rst         (RST | s_reg.eng_rst),
                .sample_tick (SAMPLE_TICK),
                .step_tick   (step_tick),
                .zc_mode     (zc_mode),
                .zero_cross  (zero_cross[ch]),
                .grant       (grant[ch]),
                .target      (target[ch]),
                .want        (want[ch]),
                .level       (level[ch])
            );
        end
    endgenerate

    // ************************************************
    // outputs
    // ************************************************
    assign LEFT_GAIN_LEVEL         = level[0];
    assign RIGHT_GAIN_LEVEL        = level[1];
    assign OVERSAMPLE_HIGH         = s_reg.format_ctrl[dmr_pkg::OVERSAMPLE_BIT];
    assign RIGHT_POLARITY_FLIP     = s_reg.format_ctrl[dmr_pkg::POLARITY_BIT];
    assign LINE_IN_BLEND_EN        = s_reg.format_ctrl[dmr_pkg::BLEND_BIT];
    assign TREBLE_CUT_FILTER_EN    = s_reg.format_ctrl[dmr_pkg::TREBLE_BIT];
    assign AUDIO_WORD_LAYOUT       = s_reg.format_ctrl[dmr_pkg::LAYOUT_LSB +: 3];
    assign ZERO_CROSSING_GAIN_STEP = zc_mode;
    assign LOW_POWER_REQ           = low_power;
    assign DIGITAL_RESET           = s_reg.eng_rst;
endmodule

//--- dmr_ctrl_top_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (g), (e)); end end
module dmr_ctrl_top_test;
    localparam int STEP_SAMPLES = 8;
    localparam int ZC_TIMEOUT   = 64;
    logic        MCLK, RST, SAMPLE_TICK, LEFT_ZERO_CROSS, RIGHT_ZERO_CROSS;
    logic        CTRL_SHIFT_CLK, CTRL_SELECT_N, CTRL_SERIAL_IN;
    logic [5:0]  LEFT_GAIN_LEVEL, RIGHT_GAIN_LEVEL;
    logic        OVERSAMPLE_HIGH, RIGHT_POLARITY_FLIP, LINE_IN_BLEND_EN, TREBLE_CUT_FILTER_EN;
    logic [2:0]  AUDIO_WORD_LAYOUT;
    logic        ZERO_CROSSING_GAIN_STEP, LOW_POWER_REQ, DIGITAL_RESET;
    int          err_count, compares;
    logic [16:0] bad_w [5];
    int          bad_n [5];

    dmr_host_model i_host (.sclk(CTRL_SHIFT_CLK), .sel_n(CTRL_SELECT_N), .sdi(CTRL_SERIAL_IN));
    dmr_ctrl_top #(.STEP_SAMPLES(STEP_SAMPLES), .ZC_TIMEOUT(ZC_TIMEOUT)) i_dut (
        .MCLK(MCLK), .RST(RST), .CTRL_SHIFT_CLK(CTRL_SHIFT_CLK), .CTRL_SELECT_N(CTRL_SELECT_N),
        .CTRL_SERIAL_IN(CTRL_SERIAL_IN), .SAMPLE_TICK(SAMPLE_TICK), .LEFT_ZERO_CROSS(LEFT_ZERO_CROSS),
        .RIGHT_ZERO_CROSS(RIGHT_ZERO_CROSS), .LEFT_GAIN_LEVEL(LEFT_GAIN_LEVEL), .RIGHT_GAIN_LEVEL(RIGHT_GAIN_LEVEL),
        .OVERSAMPLE_HIGH(OVERSAMPLE_HIGH), .RIGHT_POLARITY_FLIP(RIGHT_POLARITY_FLIP),
        .LINE_IN_BLEND_EN(LINE_IN_BLEND_EN), .TREBLE_CUT_FILTER_EN(TREBLE_CUT_FILTER_EN),
        .AUDIO_WORD_LAYOUT(AUDIO_WORD_LAYOUT), .ZERO_CROSSING_GAIN_STEP(ZERO_CROSSING_GAIN_STEP),
        .LOW_POWER_REQ(LOW_POWER_REQ), .DIGITAL_RESET(DIGITAL_RESET));

    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    // ****************************************
    // access tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    // eight idle cycles cover the synchroniser and the write latency
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        i_host.send({2'b00, idx, d}, 16);
        cyc(8);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            SAMPLE_TICK = 1'b1;
            cyc(1);
            SAMPLE_TICK = 1'b0;
            cyc(3);
        end
    endtask

    task automatic zc();
        LEFT_ZERO_CROSS  = 1'b1;
        RIGHT_ZERO_CROSS = 1'b1;
        cyc(4);
        LEFT_ZERO_CROSS  = 1'b0;
        RIGHT_ZERO_CROSS = 1'b0;
        cyc(3);
    endtask

    task automatic lv(input logic [5:0] l, input logic [5:0] r);
        `CHK(LEFT_GAIN_LEVEL, l)
        `CHK(RIGHT_GAIN_LEVEL, r)
    endtask

    task automatic cfg(input logic [7:0] e);
        `CHK({OVERSAMPLE_HIGH, 1'b0, RIGHT_POLARITY_FLIP, LINE_IN_BLEND_EN, TREBLE_CUT_FILTER_EN, AUDIO_WORD_LAYOUT}, e)
    endtask

    task automatic end_of_test();
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        RST = 1'b1;
        SAMPLE_TICK = 1'b0;
        LEFT_ZERO_CROSS = 1'b0;
        RIGHT_ZERO_CROSS = 1'b0;
        err_count = 0;
        compares = 0;
        // top bit set, index 0, index 5, 15 bits, 17 bits
        bad_w = '{17'h0_8355, 17'h0_0055, 17'h0_0555, 17'h0_0355, 17'h0_0355};
        bad_n = '{16, 16, 16, 15, 17};
        cyc(2);
        RST = 1'b0;
        cyc(2);
        lv(6'h3f, 6'h3f);
        cfg(8'h00);
        `CHK({ZERO_CROSSING_GAIN_STEP, LOW_POWER_REQ, DIGITAL_RESET}, 3'b000)
        // bit 6 kept zero as a test-only position
        for (int i = 0; i < 8; i++) begin
            wr(dmr_pkg::IDX_FORMAT, 8'(i * 37) & 8'hbf);
            cfg(8'(i * 37) & 8'hbf);
        end
        for (int i = 0; i < 5; i++) begin
            i_host.send(bad_w[i], bad_n[i]);
            cyc(8);
            cfg(8'h03);
        end
        wr(dmr_pkg::IDX_LEFT, 8'h3d);
        ticks(7);
        lv(6'h3f, 6'h3f);
        ticks(1);
        lv(6'h3e, 6'h3f);
        ticks(8);
        lv(6'h3d, 6'h3f);
        ticks(16);
        lv(6'h3d, 6'h3f);
        // right silence lives in the left register and overrides the right code
        wr(dmr_pkg::IDX_RIGHT, 8'h30);
        wr(dmr_pkg::IDX_LEFT, 8'hbd);
        ticks(520);
        lv(6'h3d, 6'h00);
        wr(dmr_pkg::IDX_LEFT, 8'h7a);
        ticks(496);
        lv(6'h00, 6'h30);
        wr(dmr_pkg::IDX_LEFT, 8'h3a);
        ticks(480);
        lv(6'h3a, 6'h30);
        wr(dmr_pkg::IDX_ZCPWR, 8'h10);
        `CHK(ZERO_CROSSING_GAIN_STEP, 1'b1)
        wr(dmr_pkg::IDX_LEFT, 8'h39);
        wr(dmr_pkg::IDX_RIGHT, 8'h2f);
        ticks(8);
        lv(6'h3a, 6'h30);
        zc();
        lv(6'h39, 6'h2f);
        wr(dmr_pkg::IDX_LEFT, 8'h38);
        ticks(8);
        lv(6'h39, 6'h2f);
        ticks(ZC_TIMEOUT - 1);
        lv(6'h39, 6'h2f);
        ticks(1);
        lv(6'h38, 6'h2f);
        // polarity flip is already zero before entering low power
        wr(dmr_pkg::IDX_ZCPWR, 8'h00);
        wr(dmr_pkg::IDX_ZCPWR, 8'h01);
        `CHK({LOW_POWER_REQ, DIGITAL_RESET}, 2'b11)
        lv(6'h3f, 6'h3f);
        cfg(8'h03);
        wr(dmr_pkg::IDX_ZCPWR, 8'h00);
        ticks(140);
        lv(6'h38, 6'h2f);
        `CHK(DIGITAL_RESET, 1'b0)
        end_of_test();
    end

    initial begin
        #300_000;
        err_count++;
        end_of_test();
    end
endmodule

bind dmr_ctrl_top dmr_ctrl_sva #(.STEP_SAMPLES(STEP_SAMPLES)) i_sva (
    .MCLK(MCLK), .RST(RST), .CTRL_SHIFT_CLK(CTRL_SHIFT_CLK), .CTRL_SELECT_N(CTRL_SELECT_N),
    .CTRL_SERIAL_IN(CTRL_SERIAL_IN), .SAMPLE_TICK(SAMPLE_TICK), .LEFT_ZERO_CROSS(LEFT_ZERO_CROSS),
    .RIGHT_ZERO_CROSS(RIGHT_ZERO_CROSS), .LEFT_GAIN_LEVEL(LEFT_GAIN_LEVEL), .RIGHT_GAIN_LEVEL(RIGHT_GAIN_LEVEL),
    .OVERSAMPLE_HIGH(OVERSAMPLE_HIGH), .RIGHT_POLARITY_FLIP(RIGHT_POLARITY_FLIP),
    .LINE_IN_BLEND_EN(LINE_IN_BLEND_EN), .TREBLE_CUT_FILTER_EN(TREBLE_CUT_FILTER_EN),
    .AUDIO_WORD_LAYOUT(AUDIO_WORD_LAYOUT), .ZERO_CROSSING_GAIN_STEP(ZERO_CROSSING_GAIN_STEP),
    .LOW_POWER_REQ(LOW_POWER_REQ), .DIGITAL_RESET(DIGITAL_RESET));

//--- dmr_gain_ramp.sv
`timescale 1ns/100ps
module dmr_gain_ramp #(
    parameter int GAIN_W  = 6,
    parameter int TIMEOUT = 512
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              sample_tick,
    input  wire logic              step_tick,
    input  wire logic              zc_mode,
    input  wire logic              zero_cross,
    input  wire logic              grant,
    input  wire logic [GAIN_W-1:0] target,
    output logic                   want,
    output logic      [GAIN_W-1:0] level
);
    localparam int CNT_W = $clog2(TIMEOUT + 1);

    initial begin
        if (GAIN_W < 1 || TIMEOUT < 1) begin
            $error("dmr_gain_ramp: bad parameters");
        end
    end

    typedef struct packed {
        dmr_pkg::dmr_ch_state_t state;
        logic [GAIN_W-1:0]      level;
        logic [CNT_W-1:0]       wait_cnt;
    } dmr_ramp_state_t;

    localparam dmr_ramp_state_t RAMP_RST = '{
        state:    dmr_pkg::CH_IDLE,
        level:    {GAIN_W{1'b1}},
        wait_cnt: '0
    };

    dmr_ramp_state_t r_reg;
    dmr_ramp_state_t r_next;
    logic            timed_out;

    assign timed_out = (r_reg.wait_cnt == CNT_W'(TIMEOUT));
    assign level     = r_reg.level;
    // in zero-cross mode a step waits for a crossing or the timeout
    assign want = (r_reg.state == dmr_pkg::CH_ARMED) && (r_reg.level != target)
                  && (!zc_mode || zero_cross || timed_out);

    always_comb begin
        r_next = r_reg;
        case (r_reg.state)
            dmr_pkg::CH_IDLE: begin
                // one step per 8-sample tick toward the target
                if (step_tick && r_reg.level != target) begin
                    r_next.state    = dmr_pkg::CH_ARMED;
                    r_next.wait_cnt = '0;
                end
            end
            dmr_pkg::CH_ARMED: begin
                if (r_reg.level == target) begin
                    r_next.state = dmr_pkg::CH_IDLE;
                end else if (grant) begin
                    // single 1 dB step, direction from target
                    if (target > r_reg.level) begin
                        r_next.level = r_reg.level + GAIN_W'(1);
                    end else begin
                        r_next.level = r_reg.level - GAIN_W'(1);
                    end
                    r_next.state = dmr_pkg::CH_IDLE;
                end else if (sample_tick && !timed_out) begin
                    r_next.wait_cnt = r_reg.wait_cnt + CNT_W'(1);
                end
            end
            default: begin
                r_next = RAMP_RST;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= RAMP_RST;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

//--- dmr_host_model.sv
`timescale 1ns/100ps
module dmr_host_model (
    output logic sclk,
    output logic sel_n,
    output logic sdi
);
    // shift clock stands still low outside frames
    initial begin
        sclk  = 1'b0;
        sel_n = 1'b1;
        sdi   = 1'b0;
    end

    // sends the low n bits of w, first bit first; n other than 16 is a deliberate bad frame
    task automatic send(input logic [16:0] w, input int n);
        sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        sel_n = 1'b1;
        sdi   = ~sdi;
        #200;
    endtask
endmodule

//--- dmr_pkg.sv
package dmr_pkg;

    // ************************************************
    // frame layout
    // ************************************************
    localparam int FRAME_BITS     = 16;
    localparam int FRAME_ZERO_BIT = 15;
    localparam int INDEX_LSB      = 8;
    localparam int INDEX_W        = 7;
    localparam int DATA_W         = 8;
    localparam int GAIN_W         = 6;

    localparam logic [6:0] IDX_LEFT   = 7'h01;
    localparam logic [6:0] IDX_RIGHT  = 7'h02;
    localparam logic [6:0] IDX_FORMAT = 7'h03;
    localparam logic [6:0] IDX_ZCPWR  = 7'h04;

    // ************************************************
    // field positions
    // ************************************************
    localparam int SILENCE_R_BIT  = 7;
    localparam int SILENCE_L_BIT  = 6;
    localparam int GAIN_LSB       = 0;
    localparam int OVERSAMPLE_BIT = 7;
    localparam int POLARITY_BIT   = 5;
    localparam int BLEND_BIT      = 4;
    localparam int TREBLE_BIT     = 3;
    localparam int LAYOUT_LSB     = 0;
    localparam int ZC_BIT         = 4;
    localparam int LOW_POWER_BIT  = 0;

    // ************************************************
    // reset values and gain codes
    // ************************************************
    localparam logic [7:0] LEFT_RST   = 8'h3f;
    localparam logic [7:0] RIGHT_RST  = 8'h3f;
    localparam logic [7:0] FORMAT_RST = 8'h00;
    localparam logic [7:0] ZCPWR_RST  = 8'h00;
    localparam logic [5:0] GAIN_MAX   = 6'h3f;
    localparam logic [5:0] GAIN_MUTE  = 6'h00;

    // ************************************************
    // timing in sample periods
    // ************************************************
    localparam int STEP_SAMPLES       = 8;
    localparam int ZC_TIMEOUT_SAMPLES = 512;

    typedef enum logic [2:0] {
        LAYOUT_LEFT_JUST   = 3'b000,
        LAYOUT_I2S         = 3'b001,
        LAYOUT_RIGHT_24    = 3'b010,
        LAYOUT_RIGHT_20    = 3'b011,
        LAYOUT_RIGHT_16    = 3'b100,
        LAYOUT_LEFT_MASTER = 3'b101,
        LAYOUT_RSVD_6      = 3'b110,
        LAYOUT_RSVD_7      = 3'b111
    } dmr_layout_t;

    typedef enum logic [0:0] {
        CH_IDLE  = 1'b0,
        CH_ARMED = 1'b1
    } dmr_ch_state_t;

endpackage
